/* File: design/lio_pkg.sv */
// Purpose: shared constants, operations and carriers for the low i/o register space
// Assumes: one 50 MHz clock, synchronous active-high reset
// Notes:   offsets are i/o addresses; data-space addresses add DATA_IO_BASE
package lio_pkg;

	// ----------------------------------------------------------------
	// widths and address windows
	// ----------------------------------------------------------------
	localparam int unsigned DATA_W     = 8;
	localparam int unsigned ADDR_W     = 8;
	localparam int unsigned IO_W       = 6;
	localparam int unsigned BIT_W      = 3;
	localparam int unsigned NUM_FLAGS  = 5;
	localparam int unsigned CLK_MHZ    = 50;

	localparam logic [7:0] DATA_IO_BASE = 8'h20;
	localparam logic [7:0] DATA_IO_TOP  = 8'h5F;
	localparam logic [7:0] EXT_IO_LO    = 8'h60;
	localparam logic [7:0] EXT_IO_HI    = 8'hFF;
	localparam logic [5:0] IO_TOP       = 6'h3F;
	localparam logic [5:0] BIT_IO_TOP   = 6'h1F;

	// ----------------------------------------------------------------
	// register offsets (i/o address)
	// ----------------------------------------------------------------
	localparam logic [5:0] OFS_PORT_B_INPUT     = 6'h03;
	localparam logic [5:0] OFS_PORT_B_DIRECTION = 6'h04;
	localparam logic [5:0] OFS_PORT_B_OUTPUT    = 6'h05;
	localparam logic [5:0] OFS_PORT_C_INPUT     = 6'h06;
	localparam logic [5:0] OFS_PORT_C_DIRECTION = 6'h07;
	localparam logic [5:0] OFS_PORT_C_OUTPUT    = 6'h08;
	localparam logic [5:0] OFS_PORT_D_INPUT     = 6'h09;
	localparam logic [5:0] OFS_PORT_D_DIRECTION = 6'h0A;
	localparam logic [5:0] OFS_PORT_D_OUTPUT    = 6'h0B;
	localparam logic [5:0] OFS_TIMER0_FLAGS     = 6'h15;
	localparam logic [5:0] OFS_TIMER1_FLAGS     = 6'h16;
	localparam logic [5:0] OFS_TIMER2_FLAGS     = 6'h17;
	localparam logic [5:0] OFS_PIN_CHANGE_FLAGS = 6'h1B;
	localparam logic [5:0] OFS_EXT_IRQ_FLAGS    = 6'h1C;
	localparam logic [5:0] OFS_EXT_IRQ_MASK     = 6'h1D;
	localparam logic [5:0] OFS_SCRATCH_BYTE_0   = 6'h1E;
	localparam logic [5:0] OFS_NV_CONTROL       = 6'h1F;
	localparam logic [5:0] OFS_NV_DATA          = 6'h20;
	localparam logic [5:0] OFS_NV_ADDR_LOW      = 6'h21;
	localparam logic [5:0] OFS_NV_ADDR_HIGH     = 6'h22;

	// ----------------------------------------------------------------
	// implemented-bit masks and reset value
	// ----------------------------------------------------------------
	localparam logic [7:0] MASK_FULL          = 8'hFF;
	localparam logic [7:0] MASK_PORT_C        = 8'h7F;
	localparam logic [7:0] MASK_TIMER0_FLAGS  = 8'h07;
	localparam logic [7:0] MASK_TIMER1_FLAGS  = 8'h27;
	localparam logic [7:0] MASK_TIMER2_FLAGS  = 8'h07;
	localparam logic [7:0] MASK_PIN_CHG_FLAGS = 8'h07;
	localparam logic [7:0] MASK_EXT_IRQ_FLAGS = 8'h03;
	localparam logic [7:0] MASK_EXT_IRQ_MASK  = 8'h03;
	localparam logic [7:0] MASK_NV_CONTROL    = 8'h3F;
	localparam logic [7:0] RST_BYTE           = 8'h00;

	// flag register slots, index order matches lio_flag_s
	localparam int unsigned FLAG_TIMER0  = 0;
	localparam int unsigned FLAG_TIMER1  = 1;
	localparam int unsigned FLAG_TIMER2  = 2;
	localparam int unsigned FLAG_PIN_CHG = 3;
	localparam int unsigned FLAG_EXT_IRQ = 4;
	localparam logic [NUM_FLAGS-1:0][7:0] FLAG_MASKS = {
		MASK_EXT_IRQ_FLAGS, MASK_PIN_CHG_FLAGS, MASK_TIMER2_FLAGS,
		MASK_TIMER1_FLAGS, MASK_TIMER0_FLAGS};

	// ----------------------------------------------------------------
	// operations and carriers
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		LIO_OP_NONE,
		LIO_OP_IO_READ,
		LIO_OP_IO_WRITE,
		LIO_OP_MEMORY_READ,
		LIO_OP_MEMORY_WRITE,
		LIO_OP_SET_IO_BIT,
		LIO_OP_CLEAR_IO_BIT,
		LIO_OP_SKIP_IF_IO_BIT_ONE,
		LIO_OP_SKIP_IF_IO_BIT_ZERO
	} lio_op_e;

	typedef struct packed {
		lio_op_e    op;
		logic [7:0] addr;
		logic [2:0] bit_sel;
		logic [7:0] wdata;
	} lio_req_s;

	typedef struct packed {
		logic [7:0] ext_irq;
		logic [7:0] pin_chg;
		logic [7:0] timer2;
		logic [7:0] timer1;
		logic [7:0] timer0;
	} lio_flag_s;

	typedef struct packed {
		logic [7:0] d_out;
		logic [7:0] d_dir;
		logic [7:0] c_out;
		logic [7:0] c_dir;
		logic [7:0] b_out;
		logic [7:0] b_dir;
	} lio_port_s;

	typedef struct packed {
		logic [7:0] nv_addr_high;
		logic [7:0] nv_addr_low;
		logic [7:0] nv_data;
		logic [7:0] nv_control;
		logic [7:0] scratch;
		logic [7:0] ext_irq_mask;
	} lio_ctrl_s;

endpackage

/* File: design/lio_decode.sv */
// Purpose: maps an access onto the 64-entry i/o space and classifies it
// Assumes: requests carry a decoded operation
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module lio_decode (
	// request
	input  wire lio_pkg::lio_op_e i_op,
	input  wire logic [7:0]       i_addr,
	// classification
	output logic [5:0]            o_io_idx,
	output logic                  o_in_space,
	output logic                  o_is_write,
	output logic                  o_is_bit,
	output logic                  o_is_skip
);
	wire is_io    = (i_op == lio_pkg::LIO_OP_IO_READ) || (i_op == lio_pkg::LIO_OP_IO_WRITE);
	wire is_mem   = (i_op == lio_pkg::LIO_OP_MEMORY_READ) || (i_op == lio_pkg::LIO_OP_MEMORY_WRITE);
	wire is_set   = (i_op == lio_pkg::LIO_OP_SET_IO_BIT) || (i_op == lio_pkg::LIO_OP_CLEAR_IO_BIT);
	wire is_skip  = (i_op == lio_pkg::LIO_OP_SKIP_IF_IO_BIT_ONE)
		|| (i_op == lio_pkg::LIO_OP_SKIP_IF_IO_BIT_ZERO);
	wire [7:0] mem_off = i_addr - lio_pkg::DATA_IO_BASE;
	wire mem_in   = (i_addr >= lio_pkg::DATA_IO_BASE) && (i_addr <= lio_pkg::DATA_IO_TOP);
	wire bit_in   = (i_addr[5:0] <= lio_pkg::BIT_IO_TOP) && (i_addr[7:6] == 2'b00);

	assign o_io_idx   = is_mem ? mem_off[5:0] : i_addr[5:0];
	assign o_in_space = is_io || (is_mem && mem_in) || ((is_set || is_skip) && bit_in);
	assign o_is_write = (i_op == lio_pkg::LIO_OP_IO_WRITE) || (i_op == lio_pkg::LIO_OP_MEMORY_WRITE)
		|| is_set;
	assign o_is_bit   = is_set;
	assign o_is_skip  = is_skip;
endmodule
`default_nettype wire

/* File: design/lio_flag_reg.sv */
// Purpose: one byte of hardware-set, write-one-to-clear status flags
// Assumes: set and clear strobes are single-cycle
// Notes:   unimplemented bits stay zero
`timescale 1ns/1ps
`default_nettype none
module lio_flag_reg #(
	parameter logic [7:0] VALID = 8'hFF
) (
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// strobes
	input  wire logic [7:0] i_set,
	input  wire logic [7:0] i_clr,
	// state
	output logic [7:0]      o_flags
);
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_bit
			if (VALID[g]) begin : g_impl
				always_ff @(posedge i_clk) begin
					if (i_rst) begin
						o_flags[g] <= 1'b0;
					end else if (i_set[g]) begin
						o_flags[g] <= 1'b1;
					end else if (i_clr[g]) begin
						o_flags[g] <= 1'b0;
					end
				end
			end else begin : g_rsvd
				assign o_flags[g] = 1'b0;
			end
		end
	endgenerate
endmodule
`default_nettype wire

/* File: design/lio_register_space.sv */
// Purpose: low i/o register space: ports, flags, scratch and non-volatile interface bytes
// Assumes: the core presents one request per cycle; pins are synchronous to i_clk
// Notes:   answers one cycle after the request; writes land on the request edge
`timescale 1ns/1ps
`default_nettype none
module lio_register_space (
	// clock and reset
	input  wire logic               i_clk,
	input  wire logic               i_rst,
	// core access
	input  wire lio_pkg::lio_req_s  i_req,
	output logic                    o_ack,
	output logic                    o_hit,
	output logic                    o_refused,
	output logic                    o_skip,
	output logic [7:0]              o_rdata,
	// port pins
	input  wire logic [7:0]         i_pin_b,
	input  wire logic [7:0]         i_pin_c,
	input  wire logic [7:0]         i_pin_d,
	// peripheral events
	input  wire lio_pkg::lio_flag_s i_evt,
	// register contents
	output lio_pkg::lio_port_s      o_port,
	output lio_pkg::lio_ctrl_s      o_ctrl,
	output lio_pkg::lio_flag_s      o_flags
);

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic [5:0] io_idx;
	logic       in_space;
	logic       is_write;
	logic       is_bit;
	logic       is_skip;

	lio_decode u_decode (
		.i_op       (i_req.op),
		.i_addr     (i_req.addr),
		.o_io_idx   (io_idx),
		.o_in_space (in_space),
		.o_is_write (is_write),
		.o_is_bit   (is_bit),
		.o_is_skip  (is_skip)
	);

	wire active   = (i_req.op != lio_pkg::LIO_OP_NONE);
	wire do_write = in_space && is_write;

	// ----------------------------------------------------------------
	// write data and lane mask
	// ----------------------------------------------------------------
	wire [7:0] bit_onehot = 8'h01 << i_req.bit_sel;
	wire       bit_value  = (i_req.op == lio_pkg::LIO_OP_SET_IO_BIT);
	wire [7:0] wr_mask    = is_bit ? bit_onehot : lio_pkg::MASK_FULL;
	wire [7:0] wr_data    = is_bit ? {8{bit_value}} : i_req.wdata;
	wire [7:0] w1c_data   = wr_data & wr_mask;

	function automatic logic [7:0] merge(
		input logic [7:0] old_val,
		input logic [7:0] mask,
		input logic [7:0] data,
		input logic [7:0] valid
	);
		merge = ((old_val & ~mask) | (data & mask)) & valid;
	endfunction

	// ----------------------------------------------------------------
	// per-register write enables
	// ----------------------------------------------------------------
	wire we_b_dir    = do_write && (io_idx == lio_pkg::OFS_PORT_B_DIRECTION);
	wire we_b_out    = do_write && (io_idx == lio_pkg::OFS_PORT_B_OUTPUT);
	wire we_c_dir    = do_write && (io_idx == lio_pkg::OFS_PORT_C_DIRECTION);
	wire we_c_out    = do_write && (io_idx == lio_pkg::OFS_PORT_C_OUTPUT);
	wire we_d_dir    = do_write && (io_idx == lio_pkg::OFS_PORT_D_DIRECTION);
	wire we_d_out    = do_write && (io_idx == lio_pkg::OFS_PORT_D_OUTPUT);
	wire we_t0       = do_write && (io_idx == lio_pkg::OFS_TIMER0_FLAGS);
	wire we_t1       = do_write && (io_idx == lio_pkg::OFS_TIMER1_FLAGS);
	wire we_t2       = do_write && (io_idx == lio_pkg::OFS_TIMER2_FLAGS);
	wire we_pcf      = do_write && (io_idx == lio_pkg::OFS_PIN_CHANGE_FLAGS);
	wire we_eif      = do_write && (io_idx == lio_pkg::OFS_EXT_IRQ_FLAGS);
	wire we_ext_irq_mask    = do_write && (io_idx == lio_pkg::OFS_EXT_IRQ_MASK);
	wire we_scratch  = do_write && (io_idx == lio_pkg::OFS_SCRATCH_BYTE_0);
	wire we_nv_ctl   = do_write && (io_idx == lio_pkg::OFS_NV_CONTROL);
	wire we_nv_data  = do_write && (io_idx == lio_pkg::OFS_NV_DATA);
	wire we_nv_lo    = do_write && (io_idx == lio_pkg::OFS_NV_ADDR_LOW);
	wire we_nv_hi    = do_write && (io_idx == lio_pkg::OFS_NV_ADDR_HIGH);

	// ----------------------------------------------------------------
	// plain storage
	// ----------------------------------------------------------------
	logic [7:0] b_dir;
	logic [7:0] b_out;
	logic [7:0] c_dir;
	logic [7:0] c_out;
	logic [7:0] d_dir;
	logic [7:0] d_out;
	logic [7:0] ext_irq_mask;
	logic [7:0] scratch;
	logic [7:0] nv_control;
	logic [7:0] nv_data;
	logic [7:0] nv_addr_low;
	logic [7:0] nv_addr_high;

	wire [7:0] next_b_dir    = merge(b_dir, wr_mask, wr_data, lio_pkg::MASK_FULL);
	wire [7:0] next_b_out    = merge(b_out, wr_mask, wr_data, lio_pkg::MASK_FULL);
	wire [7:0] next_c_dir    = merge(c_dir, wr_mask, wr_data, lio_pkg::MASK_PORT_C);
	wire [7:0] next_c_out    = merge(c_out, wr_mask, wr_data, lio_pkg::MASK_PORT_C);
	wire [7:0] next_d_dir    = merge(d_dir, wr_mask, wr_data, lio_pkg::MASK_FULL);
	wire [7:0] next_d_out    = merge(d_out, wr_mask, wr_data, lio_pkg::MASK_FULL);
	wire [7:0] next_ext_irq_mask    = merge(ext_irq_mask, wr_mask, wr_data,
		lio_pkg::MASK_EXT_IRQ_MASK);
	wire [7:0] next_scratch  = merge(scratch, wr_mask, wr_data, lio_pkg::MASK_FULL);
	wire [7:0] next_nv_ctl   = merge(nv_control, wr_mask, wr_data,
		lio_pkg::MASK_NV_CONTROL);
	wire [7:0] next_nv_data  = merge(nv_data, wr_mask, wr_data, lio_pkg::MASK_FULL);
	wire [7:0] next_nv_lo    = merge(nv_addr_low, wr_mask, wr_data, lio_pkg::MASK_FULL);
	wire [7:0] next_nv_hi    = merge(nv_addr_high, wr_mask, wr_data, lio_pkg::MASK_FULL);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			b_dir <= lio_pkg::RST_BYTE;
			b_out <= lio_pkg::RST_BYTE;
			c_dir <= lio_pkg::RST_BYTE;
			c_out <= lio_pkg::RST_BYTE;
			d_dir <= lio_pkg::RST_BYTE;
			d_out <= lio_pkg::RST_BYTE;
		end else begin
			if (we_b_dir) b_dir <= next_b_dir;
			if (we_b_out) b_out <= next_b_out;
			if (we_c_dir) c_dir <= next_c_dir;
			if (we_c_out) c_out <= next_c_out;
			if (we_d_dir) d_dir <= next_d_dir;
			if (we_d_out) d_out <= next_d_out;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ext_irq_mask <= lio_pkg::RST_BYTE;
			scratch      <= lio_pkg::RST_BYTE;
			nv_control   <= lio_pkg::RST_BYTE;
		end else begin
			if (we_ext_irq_mask) ext_irq_mask <= next_ext_irq_mask;
			if (we_scratch) scratch <= next_scratch;
			if (we_nv_ctl) nv_control <= next_nv_ctl;
		end
	end

	// these sit above 0x1F, so only byte writes reach them
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			nv_data      <= lio_pkg::RST_BYTE;
			nv_addr_low  <= lio_pkg::RST_BYTE;
			nv_addr_high <= lio_pkg::RST_BYTE;
		end else begin
			if (we_nv_data) nv_data <= next_nv_data;
			if (we_nv_lo) nv_addr_low <= next_nv_lo;
			if (we_nv_hi) nv_addr_high <= next_nv_hi;
		end
	end

	// ----------------------------------------------------------------
	// write-one-to-clear flag registers
	// ----------------------------------------------------------------
	wire [lio_pkg::NUM_FLAGS-1:0]      flag_we = {we_eif, we_pcf, we_t2, we_t1, we_t0};
	wire [lio_pkg::NUM_FLAGS-1:0][7:0] flag_set = i_evt;
	logic [lio_pkg::NUM_FLAGS-1:0][7:0] flag_q;

	genvar f;
	generate
		for (f = 0; f < lio_pkg::NUM_FLAGS; f++) begin : g_flag
			wire [7:0] clr = flag_we[f] ? w1c_data : 8'h00;
			lio_flag_reg #(
				.VALID (lio_pkg::FLAG_MASKS[f])
			) u_flag (
				.i_clk   (i_clk),
				.i_rst   (i_rst),
				.i_set   (flag_set[f]),
				.i_clr   (clr),
				.o_flags (flag_q[f])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// read selection
	// ----------------------------------------------------------------
	logic [7:0] rd_value;
	logic       rd_impl;

	always_comb begin
		rd_value = 8'h00;
		rd_impl  = 1'b1;
		unique case (io_idx)
			lio_pkg::OFS_PORT_B_INPUT:     rd_value = i_pin_b;
			lio_pkg::OFS_PORT_B_DIRECTION: rd_value = b_dir;
			lio_pkg::OFS_PORT_B_OUTPUT:    rd_value = b_out;
			lio_pkg::OFS_PORT_C_INPUT:     rd_value = i_pin_c & lio_pkg::MASK_PORT_C;
			lio_pkg::OFS_PORT_C_DIRECTION: rd_value = c_dir;
			lio_pkg::OFS_PORT_C_OUTPUT:    rd_value = c_out;
			lio_pkg::OFS_PORT_D_INPUT:     rd_value = i_pin_d;
			lio_pkg::OFS_PORT_D_DIRECTION: rd_value = d_dir;
			lio_pkg::OFS_PORT_D_OUTPUT:    rd_value = d_out;
			lio_pkg::OFS_TIMER0_FLAGS:     rd_value = flag_q[lio_pkg::FLAG_TIMER0];
			lio_pkg::OFS_TIMER1_FLAGS:     rd_value = flag_q[lio_pkg::FLAG_TIMER1];
			lio_pkg::OFS_TIMER2_FLAGS:     rd_value = flag_q[lio_pkg::FLAG_TIMER2];
			lio_pkg::OFS_PIN_CHANGE_FLAGS: rd_value = flag_q[lio_pkg::FLAG_PIN_CHG];
			lio_pkg::OFS_EXT_IRQ_FLAGS:    rd_value = flag_q[lio_pkg::FLAG_EXT_IRQ];
			lio_pkg::OFS_EXT_IRQ_MASK:     rd_value = ext_irq_mask;
			lio_pkg::OFS_SCRATCH_BYTE_0:   rd_value = scratch;
			lio_pkg::OFS_NV_CONTROL:       rd_value = nv_control;
			lio_pkg::OFS_NV_DATA:          rd_value = nv_data;
			lio_pkg::OFS_NV_ADDR_LOW:      rd_value = nv_addr_low;
			lio_pkg::OFS_NV_ADDR_HIGH:     rd_value = nv_addr_high;
			default:                       rd_impl  = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// skip test
	// ----------------------------------------------------------------
	wire sampled_bit = rd_value[i_req.bit_sel];
	wire want_one    = (i_req.op == lio_pkg::LIO_OP_SKIP_IF_IO_BIT_ONE);
	wire skip_now    = in_space && is_skip && (sampled_bit == want_one);

	// ----------------------------------------------------------------
	// answer
	// ----------------------------------------------------------------
	wire [7:0] next_rdata = (in_space && !is_write) ? rd_value : 8'h00;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_ack     <= 1'b0;
			o_hit     <= 1'b0;
			o_refused <= 1'b0;
			o_skip    <= 1'b0;
			o_rdata   <= 8'h00;
		end else begin
			o_ack     <= active;
			o_hit     <= active && in_space && rd_impl;
			o_refused <= active && !in_space;
			o_skip    <= skip_now;
			o_rdata   <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign o_port.b_dir = b_dir;
	assign o_port.b_out = b_out;
	assign o_port.c_dir = c_dir;
	assign o_port.c_out = c_out;
	assign o_port.d_dir = d_dir;
	assign o_port.d_out = d_out;

	assign o_ctrl.ext_irq_mask = ext_irq_mask;
	assign o_ctrl.scratch      = scratch;
	assign o_ctrl.nv_control   = nv_control;
	assign o_ctrl.nv_data      = nv_data;
	assign o_ctrl.nv_addr_low  = nv_addr_low;
	assign o_ctrl.nv_addr_high = nv_addr_high;

	assign o_flags = flag_q;

endmodule
`default_nettype wire

/* File: bench/lio_core_model.sv */
// Purpose: core-side request source for the low i/o register space
// Assumes: the bench changes commands on the falling edge
// Notes:   i_break lets a scenario write reserved places on purpose
`timescale 1ns/1ps
`default_nettype none
module lio_core_model (
	// command from the bench
	input  wire lio_pkg::lio_req_s i_cmd,
	input  wire logic [7:0]        i_valid,
	input  wire logic              i_break,
	// request to the register space
	output var lio_pkg::lio_req_s  o_req
);
	wire logic wr = i_cmd.op inside {lio_pkg::LIO_OP_IO_WRITE, lio_pkg::LIO_OP_MEMORY_WRITE,
		lio_pkg::LIO_OP_SET_IO_BIT, lio_pkg::LIO_OP_CLEAR_IO_BIT};
	always_comb begin
		o_req = i_cmd;
		if (!i_break) begin
			o_req.wdata = i_cmd.wdata & i_valid;
			if (wr && i_valid == 8'h00) begin
				o_req.op = lio_pkg::LIO_OP_NONE;
			end
		end
	end
endmodule
`default_nettype wire

/* File: bench/lio_register_space_chk.sv */
// Purpose: port assertions for the low i/o register space
// Assumes: one clock, synchronous reset
// Notes:   bound below the module
`timescale 1ns/1ps
`default_nettype none
module lio_register_space_chk (
	// clock and reset
	input wire logic               i_clk,
	input wire logic               i_rst,
	// core access
	input wire lio_pkg::lio_req_s  i_req,
	input wire logic               o_ack,
	input wire logic               o_hit,
	input wire logic               o_refused,
	input wire logic               o_skip,
	input wire logic [7:0]         o_rdata,
	// pins and events
	input wire logic [7:0]         i_pin_b,
	input wire logic [7:0]         i_pin_c,
	input wire logic [7:0]         i_pin_d,
	input wire lio_pkg::lio_flag_s i_evt,
	// register contents
	input wire lio_pkg::lio_port_s o_port,
	input wire lio_pkg::lio_ctrl_s o_ctrl,
	input wire lio_pkg::lio_flag_s o_flags
);
	// ----------------------------------------------------------------
	// request decode
	// ----------------------------------------------------------------
	wire logic       ior = i_req.op == lio_pkg::LIO_OP_IO_READ;
	wire logic       iow = i_req.op == lio_pkg::LIO_OP_IO_WRITE;
	wire logic       mw  = i_req.op == lio_pkg::LIO_OP_MEMORY_WRITE;
	wire logic       mem = mw || i_req.op == lio_pkg::LIO_OP_MEMORY_READ;
	wire logic       sb  = i_req.op == lio_pkg::LIO_OP_SET_IO_BIT;
	wire logic       cb  = i_req.op == lio_pkg::LIO_OP_CLEAR_IO_BIT;
	wire logic       s0  = i_req.op == lio_pkg::LIO_OP_SKIP_IF_IO_BIT_ZERO;
	wire logic       sk  = s0 || i_req.op == lio_pkg::LIO_OP_SKIP_IF_IO_BIT_ONE;
	wire logic [7:0] a   = i_req.addr;
	logic            sk_exp;
	always_ff @(posedge i_clk) begin
		sk_exp <= o_ctrl.scratch[i_req.bit_sel] ^ s0;
	end
	default clocking cb_main @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_bit_window_refused: assert property (
		(sb || cb) && a > 8'h1F |=> o_refused && !o_hit && $stable(o_port) && $stable(o_ctrl))
		else $error("bit op above 0x1F not refused");
	a_skip_bit_sample: assert property (
		sk && a == 8'h1E |=> o_ack && o_skip == sk_exp)
		else $error("skip result wrong");
	a_flag_w1c: assert property (
		iow && a[5:0] == 6'h15 |=> o_flags.timer0 == (($past(o_flags.timer0) & ~$past(i_req.wdata))
			| ($past(i_evt.timer0) & lio_pkg::MASK_TIMER0_FLAGS)))
		else $error("timer0 flags not write-one-to-clear");
	a_bit_set_single: assert property (
		sb && a == 8'h16 |=> o_flags.timer1 == (($past(o_flags.timer1)
			& ~(8'h01 << $past(i_req.bit_sel))) | ($past(i_evt.timer1) & lio_pkg::MASK_TIMER1_FLAGS)))
		else $error("bit set touched sibling flags");
	a_io_space_write: assert property (
		iow && a[5:0] == 6'h1E |=> o_hit && !o_refused && o_ctrl.scratch == $past(i_req.wdata))
		else $error("i/o write to scratch lost");
	a_data_offset_map: assert property (
		mw && a == 8'h3E |=> o_hit && o_ctrl.scratch == $past(i_req.wdata))
		else $error("data-space write to scratch lost");
	a_ext_space_refused: assert property (
		mem && a >= 8'h60 |=> o_refused && o_rdata == 8'h00 && $stable(o_ctrl) && $stable(o_port))
		else $error("extended address served");
	a_rsvd_read_zero: assert property (
		ior && a[5:0] < 6'h03 |=> o_ack && !o_hit && o_rdata == 8'h00)
		else $error("reserved read not zero");
	a_rsvd_write_void: assert property (
		iow && a[5:0] == 6'h0C |=> $stable(o_port) && $stable(o_ctrl))
		else $error("reserved write changed state");
endmodule
bind lio_register_space lio_register_space_chk lio_register_space_chk_i (
	.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .o_ack(o_ack), .o_hit(o_hit),
	.o_refused(o_refused), .o_skip(o_skip), .o_rdata(o_rdata), .i_pin_b(i_pin_b),
	.i_pin_c(i_pin_c), .i_pin_d(i_pin_d), .i_evt(i_evt), .o_port(o_port),
	.o_ctrl(o_ctrl), .o_flags(o_flags));
`default_nettype wire

/* File: bench/tb.sv */
// Purpose: self-checking bench for the low i/o register space
// Assumes: core model in front, expectations kept in a byte image
// Notes:   fixed seed, inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic               i_clk = 1'b0;
	logic               i_rst = 1'b1;
	lio_pkg::lio_req_s  cmd = '0;
	lio_pkg::lio_req_s  req;
	lio_pkg::lio_flag_s evt = '0;
	logic               brk = 1'b0;
	logic [7:0]         vld = 8'h00;
	logic [7:0]         pin_b = 8'h00;
	logic [7:0]         pin_c = 8'h00;
	logic [7:0]         pin_d = 8'h00;
	logic               ack, hit, refused, skip;
	logic [7:0]         rdata;
	lio_pkg::lio_port_s port;
	lio_pkg::lio_ctrl_s ctrl;
	lio_pkg::lio_flag_s flags;
	logic [7:0]         img [64];
	int                 err_total = 0;
	int                 compares = 0;
	int                 seed = 32'h2B55;
	always #10 i_clk = ~i_clk;
	lio_core_model lio_core_model_i (.i_cmd(cmd), .i_valid(vld), .i_break(brk), .o_req(req));
	lio_register_space lio_register_space_i (
		.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .o_ack(ack), .o_hit(hit),
		.o_refused(refused), .o_skip(skip), .o_rdata(rdata), .i_pin_b(pin_b),
		.i_pin_c(pin_c), .i_pin_d(pin_d), .i_evt(evt), .o_port(port), .o_ctrl(ctrl),
		.o_flags(flags));
	// ----------------------------------------------------------------
	// expectations and checks
	// ----------------------------------------------------------------
	function automatic logic [7:0] vmask(input logic [5:0] ia);
		case (ia)
			6'h03, 6'h04, 6'h05, 6'h09, 6'h0A, 6'h0B, 6'h1E, 6'h20, 6'h21, 6'h22: return 8'hFF;
			6'h06, 6'h07, 6'h08: return 8'h7F;
			6'h15, 6'h17, 6'h1B: return 8'h07;
			6'h16: return 8'h27;
			6'h1C, 6'h1D: return 8'h03;
			6'h1F: return 8'h3F;
			default: return 8'h00;
		endcase
	endfunction
	function automatic logic [7:0] rval(input logic [5:0] ia);
		case (ia)
			6'h03: return pin_b;
			6'h06: return pin_c & 8'h7F;
			6'h09: return pin_d;
			default: return img[ia];
		endcase
	endfunction
	task automatic cmp_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// one request, entered at a falling edge, answer checked one cycle later
	task automatic run(input lio_pkg::lio_op_e op, input logic [7:0] a, input logic [2:0] b,
		input logic [7:0] d, input lio_pkg::lio_flag_s e);
		logic [5:0] ia;
		logic       mm, bt, sk, rd, wr, rf, none;
		logic [7:0] v;
		cmp_byte(port.b_out, img[6'h05]);
		cmp_byte(ctrl.scratch, img[6'h1E]);
		cmp_byte(flags.timer1, img[6'h16]);
		mm = op inside {lio_pkg::LIO_OP_MEMORY_READ, lio_pkg::LIO_OP_MEMORY_WRITE};
		bt = op >= lio_pkg::LIO_OP_SET_IO_BIT;
		sk = op >= lio_pkg::LIO_OP_SKIP_IF_IO_BIT_ONE;
		rd = sk || op inside {lio_pkg::LIO_OP_IO_READ, lio_pkg::LIO_OP_MEMORY_READ};
		wr = op != lio_pkg::LIO_OP_NONE && !rd;
		rf = bt ? a > 8'h1F : mm && (a < 8'h20 || a > 8'h5F);
		ia = mm ? 6'(a - 8'h20) : a[5:0];
		vld = rf ? 8'hFF : vmask(ia);
		none = op == lio_pkg::LIO_OP_NONE || (!brk && wr && vld == 8'h00);
		pin_b = 8'($random(seed));
		pin_c = 8'($random(seed));
		pin_d = 8'($random(seed));
		cmd = '{op: op, addr: a, bit_sel: b, wdata: d};
		evt = e;
		v = (rd && !rf) ? rval(ia) : 8'h00;
		@(negedge i_clk);
		cmp_bit(ack, !none);
		cmp_bit(refused, rf && !none);
		cmp_bit(hit, !rf && !none && vld != 8'h00);
		cmp_bit(skip, sk && !rf && (v[b] ^ (op == lio_pkg::LIO_OP_SKIP_IF_IO_BIT_ZERO)));
		if (!none) cmp_byte(rdata, v);
		if (wr && !rf && !none && !(ia inside {6'h03, 6'h06, 6'h09})) begin
			if (!(ia inside {6'h15, 6'h16, 6'h17, 6'h1B, 6'h1C})) begin
				if (op == lio_pkg::LIO_OP_SET_IO_BIT) img[ia] |= (8'h01 << b) & vld;
				else if (op == lio_pkg::LIO_OP_CLEAR_IO_BIT) img[ia] &= ~(8'h01 << b);
				else img[ia] = d & vld;
			end else if (op == lio_pkg::LIO_OP_SET_IO_BIT) img[ia] &= ~(8'h01 << b);
			else if (op != lio_pkg::LIO_OP_CLEAR_IO_BIT) img[ia] &= ~d;
		end
		img[6'h15] |= e.timer0 & 8'h07;
		img[6'h16] |= e.timer1 & 8'h27;
		img[6'h17] |= e.timer2 & 8'h07;
		img[6'h1B] |= e.pin_chg & 8'h07;
		img[6'h1C] |= e.ext_irq & 8'h03;
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		for (int i = 0; i < 64; i++) img[i] = 8'h00;
		repeat (12) @(negedge i_clk);
		i_rst = 1'b0;
		@(negedge i_clk);
		for (int i = 0; i < 64; i++) run(lio_pkg::LIO_OP_IO_READ, 8'(i), 3'h0, 8'h00, '0);
		$display("test reset_read done");
		brk = 1'b1;
		for (int i = 0; i < 64; i++) begin
			run(lio_pkg::LIO_OP_IO_WRITE, 8'(i) | (8'($random(seed)) & 8'hC0), 3'h0,
				8'($random(seed)), '0);
		end
		for (int i = 0; i < 64; i++) run(lio_pkg::LIO_OP_MEMORY_READ, 8'(i + 32), 3'h0, 8'h00, '0);
		$display("test write_readback done");
		brk = 1'b0;
		for (int i = 0; i < 64; i++) begin
			run(lio_pkg::LIO_OP_NONE, 8'h00, 3'h0, 8'h00, '1);
			run(lio_pkg::LIO_OP_SET_IO_BIT, 8'(i), 3'($random(seed)), 8'h00, '0);
			run(lio_pkg::LIO_OP_CLEAR_IO_BIT, 8'(i), 3'($random(seed)), 8'h00, '0);
			run(lio_pkg::LIO_OP_SKIP_IF_IO_BIT_ONE, 8'(i), 3'($random(seed)), 8'h00, '0);
			run(lio_pkg::LIO_OP_SKIP_IF_IO_BIT_ZERO, 8'(i), 3'($random(seed)), 8'h00, '0);
		end
		$display("test bit_ops done");
		run(lio_pkg::LIO_OP_NONE, 8'h00, 3'h0, 8'h00, '1);
		run(lio_pkg::LIO_OP_IO_WRITE, 8'h15, 3'h0, 8'h05, '0);
		run(lio_pkg::LIO_OP_MEMORY_WRITE, 8'h36, 3'h0, 8'hFF, '{timer1: 8'h01, default: 8'h00});
		run(lio_pkg::LIO_OP_IO_READ, 8'h15, 3'h0, 8'h00, '0);
		run(lio_pkg::LIO_OP_IO_READ, 8'h16, 3'h0, 8'h00, '0);
		$display("test flag_clear done");
		for (int i = 0; i < 40; i++) begin
			run(lio_pkg::LIO_OP_MEMORY_WRITE, 8'h60 | 8'($random(seed)), 3'h0, 8'hA5, '0);
			run(lio_pkg::LIO_OP_MEMORY_READ, 8'($random(seed)) & 8'h1F, 3'h0, 8'h00, '0);
		end
		$display("test refused_window done");
		for (int i = 0; i < 400; i++) begin
			run(lio_pkg::lio_op_e'(4'($unsigned($random(seed)) % 9)), 8'($random(seed)),
				3'($random(seed)), 8'($random(seed)), '0);
		end
		$display("test random_traffic done");
		cmd.op = lio_pkg::LIO_OP_NONE;
		@(negedge i_clk);
		give_verdict();
	end
	initial begin
		repeat (5000) @(posedge i_clk);
		err_total++;
		give_verdict();
	end
endmodule
`default_nettype wire
